// file: slmc_pkg.sv
// package: register map, field positions and timing constants of the serial link mode control
package slmc_pkg;
    // register indices; the apb byte address is the index times four
    localparam logic [7:0]  IDX_MODE     = 8'h84;
    localparam logic [7:0]  IDX_BITRATE  = 8'h94;
    localparam logic [7:0]  IDX_BACKOFF  = 8'hc4;
    localparam logic [7:0]  IDX_IEN      = 8'hc8;
    localparam logic [7:0]  IDX_MASK0    = 8'hd5;
    localparam logic [7:0]  IDX_MASK1    = 8'he5;
    localparam logic [7:0]  IDX_ADDR0    = 8'h95;
    localparam logic [7:0]  IDX_ADDR1    = 8'ha5;
    localparam logic [7:0]  IDX_ADDR2    = 8'hb5;
    localparam logic [7:0]  IDX_ADDR3    = 8'hc5;
    localparam logic [7:0]  IDX_STATUS   = 8'hf0;
    localparam logic [7:0]  IDX_IMASK    = 8'hf1;
    localparam logic [7:0]  IDX_SLOT     = 8'hf2;
    localparam logic [7:0]  IDX_GAP      = 8'hf3;
    // mode register fields
    localparam int MODE_EXT_CLK   = 7;
    localparam int MODE_MODE_HI   = 6;
    localparam int MODE_MODE_LO   = 5;
    localparam int MODE_ADDR_W    = 4;
    localparam int MODE_CRC       = 3;
    localparam int MODE_PRE_HI    = 2;
    localparam int MODE_PRE_LO    = 1;
    localparam int MODE_FRAMING   = 0;
    // interrupt enable / status bit positions
    localparam int IEN_RX_VALID   = 0;
    localparam int IEN_RX_ERROR   = 1;
    localparam int IEN_TX_VALID   = 3;
    localparam int IEN_TX_ERROR   = 5;
    localparam logic [7:0] IEN_USED = 8'h2b;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] ALL_ONES   = 8'hff;
    // bit-rate generator: one bit per eight ticks of the reloading counter
    localparam logic [2:0] BIT_TICKS_M1 = 3'h7;
    localparam logic [6:0] PRE_0  = 7'h00;
    localparam logic [6:0] PRE_8  = 7'h08;
    localparam logic [6:0] PRE_32 = 7'h20;
    localparam logic [6:0] PRE_64 = 7'h40;
    localparam logic [6:0] MARKER_BITS = 7'h02;
    localparam logic [1:0] RESP_OKAY = 2'h0;

    typedef enum logic [1:0] {
        SLMC_NORMAL  = 2'b00,
        SLMC_RAW_TX  = 2'b01,
        SLMC_RAW_RX  = 2'b10,
        SLMC_ALT_BO  = 2'b11
    } slmc_mode_t;

    typedef enum logic [1:0] {
        SLMC_BO_IDLE = 2'b00,
        SLMC_BO_WAIT = 2'b01,
        SLMC_BO_RUN  = 2'b10
    } slmc_bo_t;

    // decoded configuration handed to the framing datapath
    typedef struct packed {
        logic       ext_tx_clock_en;
        slmc_mode_t mode;
        logic       address_width_sel;
        logic       checksum_kind;
        logic [6:0] preamble_bits;
        logic       link_framing_sel;
        logic       loopback;
        logic       raw_rx_keep_crc;
        logic       preamble_error;
    } slmc_cfg_t;

    // byte address of a printed index
    function automatic logic [11:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction : byte_addr

    // masked compare of one received byte against a match byte
    function automatic logic masked_eq(input logic [7:0] rx, input logic [7:0] ref_b,
                                       input logic [7:0] msk);
        masked_eq = ((rx ^ ref_b) & ~msk) == 8'h00;
    endfunction : masked_eq
endpackage : slmc_pkg

// file: slmc_top.sv
// serial link mode control: apb registers, bit-rate timer, backoff timer, address match
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module slmc_top (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                ext_tx_clock,
    input  wire logic                slot_tick,
    input  wire logic                gap_active,
    input  wire logic                collision,
    input  wire logic                addr_valid,
    input  wire logic [15:0]         rx_address,
    input  wire logic [3:0]          link_event,
    output logic                     tx_bit_en,
    output logic                     addr_accept,
    output logic                     backoff_done,
    output slmc_pkg::slmc_cfg_t      cfg,
    output logic                     irq
);
    typedef struct packed {
        logic [7:0]          mode_reg;
        logic [7:0]          reload;
        logic [7:0]          rate_cnt;
        logic [2:0]          bit_div;
        logic [7:0]          backoff;
        slmc_pkg::slmc_bo_t  bo_state;
        logic [7:0]          ien;
        logic [7:0]          mask0;
        logic [7:0]          mask1;
        logic [7:0]          adr0;
        logic [7:0]          adr1;
        logic [7:0]          adr2;
        logic [7:0]          adr3;
        logic [7:0]          slot_seed;
        logic [7:0]          status;
        logic [7:0]          imask;
        logic [2:0]          xclk_sync;
        logic [2:0]          slot_sync;
        logic [1:0]          gap_sync;
        logic [31:0]         prdata;
        logic                pready;
        logic                tx_bit_en;
        logic                addr_accept;
        logic                backoff_done;
        slmc_pkg::slmc_cfg_t cfg;
        logic                irq;
    } slmc_state_t;

    slmc_state_t st;
    slmc_state_t next_st;

    logic       wr_en;
    logic       rd_en;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic       rate_tick;
    logic       xclk_rise;
    logic       slot_rise;
    logic [1:0] pre_sel;
    logic       match8;
    logic       match16;
    logic [7:0] events;

    // access phase decode; one wait state, pready stands in the second access cycle
    assign wr_en = psel & penable & pwrite & st.pready;
    assign rd_en = psel & penable & ~pwrite;
    assign wbyte = pwdata[7:0];

    // read mux; bit-rate reads the live counter, backoff reads the live slot count
    always_comb begin
        rd_byte = slmc_pkg::RESET_BYTE;
        case (paddr)
            slmc_pkg::byte_addr(slmc_pkg::IDX_MODE)    : rd_byte = st.mode_reg;
            slmc_pkg::byte_addr(slmc_pkg::IDX_BITRATE) : rd_byte = st.rate_cnt;
            slmc_pkg::byte_addr(slmc_pkg::IDX_BACKOFF) : rd_byte = st.backoff;
            slmc_pkg::byte_addr(slmc_pkg::IDX_IEN)     : rd_byte = st.ien;
            slmc_pkg::byte_addr(slmc_pkg::IDX_MASK0)   : rd_byte = st.mask0;
            slmc_pkg::byte_addr(slmc_pkg::IDX_MASK1)   : rd_byte = st.mask1;
            slmc_pkg::byte_addr(slmc_pkg::IDX_ADDR0)   : rd_byte = st.adr0;
            slmc_pkg::byte_addr(slmc_pkg::IDX_ADDR1)   : rd_byte = st.adr1;
            slmc_pkg::byte_addr(slmc_pkg::IDX_ADDR2)   : rd_byte = st.adr2;
            slmc_pkg::byte_addr(slmc_pkg::IDX_ADDR3)   : rd_byte = st.adr3;
            slmc_pkg::byte_addr(slmc_pkg::IDX_STATUS)  : rd_byte = st.status;
            slmc_pkg::byte_addr(slmc_pkg::IDX_IMASK)   : rd_byte = st.imask;
            slmc_pkg::byte_addr(slmc_pkg::IDX_SLOT)    : rd_byte = st.slot_seed;
            default                                    : rd_byte = slmc_pkg::RESET_BYTE;
        endcase
    end

    // external clock edge and slot strobe come from outside: two stages before use
    assign xclk_rise = st.xclk_sync[1] & ~st.xclk_sync[2];
    assign slot_rise = st.slot_sync[1] & ~st.slot_sync[2];
    assign rate_tick = (st.rate_cnt == 8'h00);
    assign pre_sel   = {st.mode_reg[slmc_pkg::MODE_PRE_HI], st.mode_reg[slmc_pkg::MODE_PRE_LO]};

    // address compare with masks; mask0 covers the low byte, mask1 the high byte
    always_comb begin
        match8  = slmc_pkg::masked_eq(rx_address[7:0], st.adr0, st.mask0)
                | slmc_pkg::masked_eq(rx_address[7:0], st.adr1, st.mask0)
                | slmc_pkg::masked_eq(rx_address[7:0], st.adr2, st.mask0)
                | slmc_pkg::masked_eq(rx_address[7:0], st.adr3, st.mask0)
                | (rx_address[7:0] == slmc_pkg::ALL_ONES);
        match16 = (slmc_pkg::masked_eq(rx_address[7:0], st.adr0, st.mask0)
                   & slmc_pkg::masked_eq(rx_address[15:8], st.adr1, st.mask1))
                | (slmc_pkg::masked_eq(rx_address[7:0], st.adr2, st.mask0)
                   & slmc_pkg::masked_eq(rx_address[15:8], st.adr3, st.mask1))
                | (rx_address == {slmc_pkg::ALL_ONES, slmc_pkg::ALL_ONES});
    end

    // events: rx valid, rx error, tx valid, tx error into their enable positions
    always_comb begin
        events = 8'h00;
        events[slmc_pkg::IEN_RX_VALID] = link_event[0];
        events[slmc_pkg::IEN_RX_ERROR] = link_event[1];
        events[slmc_pkg::IEN_TX_VALID] = link_event[2];
        events[slmc_pkg::IEN_TX_ERROR] = link_event[3];
    end

    // next-state logic for the whole block
    always_comb begin
        next_st = st;
        next_st.xclk_sync = {st.xclk_sync[1:0], ext_tx_clock};
        next_st.slot_sync = {st.slot_sync[1:0], slot_tick};
        next_st.gap_sync  = {st.gap_sync[0], gap_active};
        next_st.pready    = 1'b0;
        next_st.prdata    = 32'h0000_0000;
        next_st.tx_bit_en = 1'b0;
        next_st.addr_accept = 1'b0;
        next_st.backoff_done = 1'b0;

        // apb: one wait state, read data registered with pready
        if (psel & penable & ~st.pready) begin
            next_st.pready = 1'b1;
            if (rd_en) begin
                next_st.prdata = {24'h000000, rd_byte};
            end
        end

        // bit-rate counter: decrement, reload at zero eight ticks per bit
        if (rate_tick) begin
            next_st.rate_cnt = st.reload;
            next_st.bit_div  = st.bit_div + 3'h1;
            if (st.bit_div == slmc_pkg::BIT_TICKS_M1) begin
                next_st.tx_bit_en = ~st.mode_reg[slmc_pkg::MODE_EXT_CLK];
            end
        end else begin
            next_st.rate_cnt = st.rate_cnt - 8'h01;
        end
        // external transmit clock replaces the generator when selected
        if (st.mode_reg[slmc_pkg::MODE_EXT_CLK]) begin
            next_st.tx_bit_en = xclk_rise;
        end

        // backoff: start on collision; alternate mode waits for the gap end
        case (st.bo_state)
            slmc_pkg::SLMC_BO_IDLE: begin
                if (collision) begin
                    next_st.backoff = st.slot_seed;
                    if (slmc_pkg::slmc_mode_t'(st.mode_reg[6:5]) == slmc_pkg::SLMC_ALT_BO) begin
                        next_st.bo_state = slmc_pkg::SLMC_BO_WAIT;
                    end else begin
                        next_st.bo_state = slmc_pkg::SLMC_BO_RUN;
                    end
                end
            end
            slmc_pkg::SLMC_BO_WAIT: begin
                if (!st.gap_sync[1]) begin
                    next_st.bo_state = slmc_pkg::SLMC_BO_RUN;
                end
            end
            slmc_pkg::SLMC_BO_RUN: begin
                if (st.backoff == 8'h00) begin
                    next_st.bo_state     = slmc_pkg::SLMC_BO_IDLE;
                    next_st.backoff_done = 1'b1;
                end else if (slot_rise) begin
                    next_st.backoff = st.backoff - 8'h01;
                end
            end
            default: next_st.bo_state = slmc_pkg::SLMC_BO_IDLE;
        endcase

        // address acceptance by address length
        if (addr_valid) begin
            next_st.addr_accept = st.mode_reg[slmc_pkg::MODE_ADDR_W] ? match16 : match8;
        end

        // register writes; backoff timer has no write path
        if (wr_en) begin
            case (paddr)
                slmc_pkg::byte_addr(slmc_pkg::IDX_MODE)    : next_st.mode_reg = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_BITRATE) : next_st.reload   = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_IEN)     : next_st.ien = wbyte & slmc_pkg::IEN_USED;
                slmc_pkg::byte_addr(slmc_pkg::IDX_MASK0)   : next_st.mask0 = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_MASK1)   : next_st.mask1 = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_ADDR0)   : next_st.adr0  = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_ADDR1)   : next_st.adr1  = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_ADDR2)   : next_st.adr2  = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_ADDR3)   : next_st.adr3  = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_IMASK)   : next_st.imask = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_SLOT)    : next_st.slot_seed = wbyte;
                slmc_pkg::byte_addr(slmc_pkg::IDX_STATUS)  : next_st.status = st.status & ~wbyte;
                default                                    : next_st.status = next_st.status;
            endcase
        end
        // sticky status: a new event wins over a write-one clear in the same cycle
        next_st.status = next_st.status | events;

        // decoded configuration for the framing datapath
        next_st.cfg.ext_tx_clock_en   = st.mode_reg[slmc_pkg::MODE_EXT_CLK];
        next_st.cfg.mode              = slmc_pkg::slmc_mode_t'(st.mode_reg[6:5]);
        next_st.cfg.address_width_sel = st.mode_reg[slmc_pkg::MODE_ADDR_W];
        next_st.cfg.checksum_kind     = st.mode_reg[slmc_pkg::MODE_CRC];
        next_st.cfg.link_framing_sel  = st.mode_reg[slmc_pkg::MODE_FRAMING];
        next_st.cfg.loopback =
            (slmc_pkg::slmc_mode_t'(st.mode_reg[6:5]) == slmc_pkg::SLMC_RAW_TX);
        next_st.cfg.raw_rx_keep_crc =
            (slmc_pkg::slmc_mode_t'(st.mode_reg[6:5]) == slmc_pkg::SLMC_RAW_RX);
        // preamble length; raw transmit sends none at all
        case (pre_sel)
            2'b00:   next_st.cfg.preamble_bits = slmc_pkg::PRE_0;
            2'b01:   next_st.cfg.preamble_bits = slmc_pkg::PRE_8;
            2'b10:   next_st.cfg.preamble_bits = slmc_pkg::PRE_32;
            default: next_st.cfg.preamble_bits = slmc_pkg::PRE_64;
        endcase
        if (next_st.cfg.loopback) begin
            next_st.cfg.preamble_bits = slmc_pkg::PRE_0;
        end
        // csma/cd count already holds the marker; zero there is an illegal setting
        next_st.cfg.preamble_error = ~st.mode_reg[slmc_pkg::MODE_FRAMING]
                                   & (pre_sel == 2'b00);

        // interrupt: status gated by mask and by the channel enables
        next_st.irq = |(next_st.status & st.imask & st.ien);
    end

    // state register; everything clears to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata       = st.prdata;
    assign pready       = st.pready;
    assign pslverr      = 1'b0;
    assign tx_bit_en    = st.tx_bit_en;
    assign addr_accept  = st.addr_accept;
    assign backoff_done = st.backoff_done;
    assign cfg          = st.cfg;
    assign irq          = st.irq;
endmodule : slmc_top
`default_nettype wire

// file: slmc_monitor.sv
// checker: apb timing, mode decode, address accept and pulse shapes
`timescale 1ns/1ps
`default_nettype none
module slmc_monitor (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pready,
    input wire logic                addr_valid,
    input wire logic [15:0]         rx_address,
    input wire logic                addr_accept,
    input wire logic                tx_bit_en,
    input wire logic                backoff_done,
    input wire slmc_pkg::slmc_cfg_t cfg
);
    localparam logic [6:0] PRE_TAB [4] = '{7'h00, 7'h08, 7'h20, 7'h40};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // mode register write taken at this edge; the decode lands two edges later
    sequence mode_wr;
        psel && penable && pready && pwrite && paddr == 12'h210;
    endsequence
    a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_cfg_fields: assert property (mode_wr |-> ##2
        {cfg.ext_tx_clock_en, cfg.mode, cfg.address_width_sel, cfg.checksum_kind,
        cfg.link_framing_sel} == {$past(pwdata[7:3], 2), $past(pwdata[0], 2)})
        else $error("mode fields not decoded");
    a_preamble_len: assert property (mode_wr |-> ##2
        cfg.preamble_bits == (($past(pwdata[6:5], 2) == 2'b01) ? 7'h00
                              : PRE_TAB[$past(pwdata[2:1], 2)])
        && cfg.preamble_error == ($past(pwdata[2:0], 2) == 3'b000)
        && cfg.loopback == ($past(pwdata[6:5], 2) == 2'b01)
        && cfg.raw_rx_keep_crc == ($past(pwdata[6:5], 2) == 2'b10))
        else $error("preamble or raw mode decode wrong");
    a_addr_cause: assert property (addr_accept |-> $past(addr_valid))
        else $error("address accepted without a received address");
    a_all_ones: assert property (addr_valid && rx_address == 16'hffff |=> addr_accept)
        else $error("all ones address refused");
    a_bit_spacing: assert property (tx_bit_en && !cfg.ext_tx_clock_en |=>
        (!tx_bit_en || cfg.ext_tx_clock_en) [*7])
        else $error("internal bit period below eight cycles");
    a_done_pulse: assert property (backoff_done |=> !backoff_done)
        else $error("backoff done held longer than one cycle");
endmodule : slmc_monitor
bind slmc_top slmc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .addr_valid(addr_valid), .rx_address(rx_address), .addr_accept(addr_accept),
    .tx_bit_en(tx_bit_en), .backoff_done(backoff_done), .cfg(cfg));
`default_nettype wire

// file: slmc_link_model.sv
// far side: stations on the shared line, slot strobe and transmit clock
`timescale 1ns/1ps
`default_nettype none
module slmc_link_model (
    input  wire logic        pclk,
    input  wire logic        run,
    input  wire logic        slot_req,
    input  wire logic        gap_req,
    input  wire logic [4:0]  pulse_req,
    input  wire logic        addr_req,
    input  wire logic [15:0] addr_word,
    output logic             ext_tx_clock,
    output logic             slot_tick,
    output logic             gap_active,
    output logic             collision,
    output logic             addr_valid,
    output logic [15:0]      rx_address,
    output logic [3:0]       link_event
);
    logic [2:0] hold;
    initial begin
        {ext_tx_clock, slot_tick, gap_active, collision, addr_valid} = 5'h00;
        rx_address = 16'h5a5a;
        link_event = 4'h0;
        hold = 3'h0;
    end
    // transmit clock stands low outside frames, phase unrelated to pclk
    always begin
        #37;
        forever begin
            #400;
            ext_tx_clock = run & ~ext_tx_clock;
        end
    end
    // line side of each request, one cycle behind it; a released address bus
    // shows the inverse of the last address, never a stale copy
    always @(posedge pclk) begin
        addr_valid <= addr_req;
        rx_address <= addr_req ? addr_word : ~addr_word;
        collision  <= pulse_req[4];
        link_event <= pulse_req[3:0];
        gap_active <= gap_req;
        // slot strobe lasts four cycles so the synchroniser cannot miss it
        hold       <= slot_req ? 3'h4 : ((hold == 3'h0) ? 3'h0 : hold - 3'h1);
        slot_tick  <= slot_req | (hold > 3'h1);
    end
endmodule : slmc_link_model
`default_nettype wire

// file: slmc_top_test.sv
// self-checking bench: registers, bit rate, backoff, address match, interrupts
`timescale 1ns/1ps
`default_nettype none
module slmc_top_test;
    localparam logic [11:0] A_MODE = 12'h210, A_RATE = 12'h250, A_BOFF = 12'h310;
    localparam logic [11:0] A_IEN = 12'h320, A_MSK0 = 12'h354, A_MSK1 = 12'h394;
    localparam logic [11:0] A_ADR0 = 12'h254, A_ADR1 = 12'h294, A_STAT = 12'h3c0;
    localparam logic [11:0] A_IMSK = 12'h3c4, A_SEED = 12'h3c8;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        ext_tx_clock, slot_tick, gap_active, collision, addr_valid;
    logic        tx_bit_en, addr_accept, backoff_done;
    logic [11:0] paddr;
    logic [15:0] rx_address;
    logic [3:0]  link_event;
    logic [4:0]  pulse_req;
    logic [15:0] addr_word;
    logic        ext_run, slot_req, gap_req, addr_req;
    logic [31:0] pwdata, prdata, q;
    slmc_pkg::slmc_cfg_t cfg;
    int          err_count, checks, dones, n, d;
    slmc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_tx_clock(ext_tx_clock), .slot_tick(slot_tick),
        .gap_active(gap_active), .collision(collision), .addr_valid(addr_valid),
        .rx_address(rx_address), .link_event(link_event), .tx_bit_en(tx_bit_en),
        .addr_accept(addr_accept), .backoff_done(backoff_done), .cfg(cfg), .irq(irq));
    slmc_link_model far (.pclk(pclk), .run(ext_run), .slot_req(slot_req), .gap_req(gap_req),
        .pulse_req(pulse_req), .addr_req(addr_req), .addr_word(addr_word),
        .ext_tx_clock(ext_tx_clock), .slot_tick(slot_tick),
        .gap_active(gap_active), .collision(collision), .addr_valid(addr_valid),
        .rx_address(rx_address), .link_event(link_event));
    always #50 pclk = ~pclk;
    // the done pulse may come while a tick task runs, so count it here
    always @(posedge pclk) if (backoff_done === 1'b1) dones <= dones + 1;
    task automatic stop_test;
        if (err_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // apb transfer: hold the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, w};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 20) err_count++;
        if (k >= 20) stop_test;
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask : apb
    // far-side requests last one cycle, except the gap level that set_gap holds; the model shapes what the line shows
    task automatic send_addr(input logic [15:0] a);
        @(posedge pclk);
        {addr_req, addr_word} <= {1'b1, a};
        @(posedge pclk);
        addr_req <= 1'b0;
    endtask : send_addr
    // index 0..3 is a link event, 4 a collision
    task automatic pulse(input int i);
        @(posedge pclk);
        pulse_req[i] <= 1'b1;
        @(posedge pclk);
        pulse_req <= 5'h00;
    endtask : pulse
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge pclk);
            slot_req <= 1'b1;
            @(posedge pclk);
            slot_req <= 1'b0;
            repeat (7) @(posedge pclk);
        end
    endtask : ticks
    task automatic set_gap(input logic b);
        @(posedge pclk);
        gap_req <= b;
        repeat (4) @(posedge pclk);
    endtask : set_gap
    // cycles from the present position up to the next bit strobe
    task automatic wait_bit;
        n = 1;
        @(negedge pclk);
        while (tx_bit_en !== 1'b1 && n < 600) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 600) err_count++;
        if (n >= 600) stop_test;
    endtask : wait_bit
    task automatic t_regs;
        logic [11:0] a [6] = '{A_MODE, A_IEN, A_MSK0, A_MSK1, A_ADR0, 12'h004};
        apb(1'b1, 12'h004, 32'h5a);
        chk("cfg reset", 32'h1, {16'h0, cfg});
        foreach (a[i]) begin
            apb(1'b0, a[i], 32'h0);
            chk("reset read", 32'h0, q);
        end
        chk("slverr", 32'h0, {31'h0, pslverr});
    endtask : t_regs
    task automatic t_mode;
        logic [7:0]  v [4] = '{8'h03, 8'hb4, 8'h5e, 8'h60};
        logic [6:0]  pre [4] = '{7'h00, 7'h08, 7'h20, 7'h40};
        logic [15:0] e;
        foreach (v[i]) begin
            apb(1'b1, A_MODE, {24'h0, v[i]});
            apb(1'b0, A_MODE, 32'h0);
            chk("mode read", {24'h0, v[i]}, q);
            e = {v[i][7:3], ((v[i][6:5] == 2'b01) ? 7'h00 : pre[v[i][2:1]]), v[i][0],
                v[i][6:5] == 2'b01, v[i][6:5] == 2'b10, v[i][2:0] == 3'b000};
            chk("cfg", {16'h0, e}, {16'h0, cfg});
        end
    endtask : t_mode
    // three divider values, then the external clock at eight cycles a bit
    task automatic t_rate;
        logic [7:0] r [3] = '{8'h00, 8'h02, 8'h05};
        apb(1'b1, A_MODE, 32'h0);
        foreach (r[i]) begin
            apb(1'b1, A_RATE, {24'h0, r[i]});
            repeat (3) wait_bit;
            chk("bit period", 32'(8 * (r[i] + 1)), n);
            apb(1'b0, A_RATE, 32'h0);
            chk("rate live", 32'h1, {31'h0, q <= {24'h0, r[i]}});
        end
        apb(1'b1, A_MODE, 32'h80);
        ext_run <= 1'b1;
        repeat (3) wait_bit;
        chk("ext bit period", 32'h8, n);
        ext_run <= 1'b0;
    endtask : t_rate
    task automatic t_backoff;
        apb(1'b1, A_MODE, 32'h02);
        apb(1'b1, A_SEED, 32'h3);
        pulse(4);
        apb(1'b1, A_BOFF, 32'hff);
        apb(1'b0, A_BOFF, 32'h0);
        chk("backoff write", 32'h3, q);
        d = dones;
        ticks(2);
        apb(1'b0, A_BOFF, 32'h0);
        chk("backoff count", 32'h1, q);
        ticks(1);
        repeat (4) @(negedge pclk);
        chk("backoff done", d + 1, dones);
        apb(1'b1, A_MODE, 32'h62);
        set_gap(1'b1);
        pulse(4);
        ticks(3);
        chk("alt hold", d + 1, dones);
        set_gap(1'b0);
        ticks(3);
        repeat (4) @(negedge pclk);
        chk("alt done", d + 2, dones);
    endtask : t_backoff
    // mode, high mask, address, expected accept
    task automatic t_addr;
        logic [39:0] t [6] = '{40'h00_00_001a_01, 40'h00_00_0052_00, 40'h00_00_ffff_01,
            40'h10_00_341a_01, 40'h10_00_351a_00, 40'h10_01_351a_01};
        apb(1'b1, A_ADR0, 32'h12);
        apb(1'b1, A_ADR1, 32'h34);
        apb(1'b1, A_MSK0, 32'h0f);
        foreach (t[i]) begin
            apb(1'b1, A_MODE, {24'h0, t[i][39:32]});
            apb(1'b1, A_MSK1, {24'h0, t[i][31:24]});
            send_addr(t[i][23:8]);
            repeat (2) @(negedge pclk);
            chk("addr accept", {31'h0, t[i][0]}, {31'h0, addr_accept});
        end
    endtask : t_addr
    task automatic t_irq;
        logic [7:0] b [4] = '{8'h01, 8'h02, 8'h08, 8'h20};
        foreach (b[i]) begin
            apb(1'b1, A_IEN, 32'h2b);
            apb(1'b1, A_IMSK, 32'h0);
            pulse(i);
            apb(1'b0, A_STAT, 32'h0);
            chk("status", {24'h0, b[i]}, q);
            chk("irq masked", 32'h0, {31'h0, irq});
            apb(1'b1, A_IMSK, 32'hff);
            repeat (3) @(negedge pclk);
            chk("irq raised", 32'h1, {31'h0, irq});
            apb(1'b1, A_IEN, {24'h0, ~b[i] & 8'h2b});
            repeat (3) @(negedge pclk);
            chk("irq disabled", 32'h0, {31'h0, irq});
            apb(1'b1, A_STAT, 32'hff);
        end
    endtask : t_irq
    initial begin
        {pclk, presetn, psel, penable, pwrite} = 5'h00;
        {paddr, pwdata} = 44'h0;
        {ext_run, slot_req, gap_req, addr_req, pulse_req, addr_word} = 25'h0;
        {err_count, checks, dones} = {32'sd0, 32'sd0, 32'sd0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_mode;
        t_rate;
        t_backoff;
        t_addr;
        t_irq;
        stop_test;
    end
endmodule : slmc_top_test
`default_nettype wire
